// File: include/dls_pkg.sv
// constants, types and register map of the directional under-frequency shedding block
// Function
// (R1) never shed a feeder whose active power supports the grid frequency; the code sheds it whenever dir_block is low
// (R2) with direction detection on, shed only a sub-grid that consumes active power; the code also sheds a feeding one whenever dir_block is low
// (R3) sign setting inverts active power: invert for load, keep for generator counting
// (R4) direction uses positive-sequence active power only; the angle method also uses positive-sequence reactive power
// (R5) a binary input blocks evaluation of the power flow direction
// (R6) direction supervision acts only when positive-sequence current reaches its minimum
// (R7) shedding released only when line-to-line voltage reaches release voltage
// (R8) method selector: power angle, active power threshold, or nondirectional/external
// (R9) power angle method blocks shedding while power lies inside the angle area
// (R10) active power method blocks trip while power exceeds the power threshold
// (R11) nondirectional without external input sheds on under-frequency alone
// (R12) nondirectional with external direction input uses it for the blocking area
// (R13) alarm when frequency below threshold and shedding not blocked
// (R14) trip delay timer starts when the function becomes alarmed
// (R15) activation inputs switch frequency threshold and delay to adaptive values
// (R16) all frequency decisions blocked while voltage below frequency-blocking voltage
// (R17) trip only if alarm lasts the whole delay; timer resets when alarm drops
package dls_pkg;

  // byte offsets of the register words
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_FREQ_THR   = 8'h04;
  localparam logic [7:0] ADDR_FREQ_ADP   = 8'h08;
  localparam logic [7:0] ADDR_DELAY      = 8'h0c;
  localparam logic [7:0] ADDR_DELAY_ADP  = 8'h10;
  localparam logic [7:0] ADDR_MIN_CUR    = 8'h14;
  localparam logic [7:0] ADDR_REL_VOLT   = 8'h18;
  localparam logic [7:0] ADDR_FBLK_VOLT  = 8'h1c;
  localparam logic [7:0] ADDR_PMIN       = 8'h20;
  localparam logic [7:0] ADDR_ANGLE_TAN  = 8'h24;
  localparam logic [7:0] ADDR_STATUS     = 8'h28;
  localparam logic [7:0] ADDR_MASK       = 8'h2c;
  localparam logic [7:0] ADDR_STATE      = 8'h30;

  // control word fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_METHOD_LSB = 1;
  localparam int CTRL_INVERT_BIT = 3;
  localparam int CTRL_EXTDIR_BIT = 4;
  localparam int CTRL_WIDTH      = 5;

  // status / mask / state fields
  localparam int EV_ALARM_BIT  = 0;
  localparam int EV_TRIP_BIT   = 1;
  localparam int EV_DIRBLK_BIT = 2;
  localparam int EV_WIDTH      = 3;
  localparam int STATE_WIDTH   = 7;

  // reset values
  localparam logic [CTRL_WIDTH-1:0] RST_CTRL      = 5'h00;
  localparam logic [15:0]           RST_FREQ_THR  = 16'hbf68;
  localparam logic [15:0]           RST_FREQ_ADP  = 16'hbb80;
  localparam logic [31:0]           RST_DELAY     = 32'h0000_0064;
  localparam logic [31:0]           RST_DELAY_ADP = 32'h0000_00c8;
  localparam logic [15:0]           RST_MIN_CUR   = 16'h0010;
  localparam logic [15:0]           RST_REL_VOLT  = 16'h0100;
  localparam logic [15:0]           RST_FBLK_VOLT = 16'h0080;
  localparam logic [23:0]           RST_PMIN      = 24'h000000;
  localparam logic [15:0]           RST_ANGLE_TAN = 16'h0100;
  localparam logic [EV_WIDTH-1:0]   RST_MASK      = 3'h0;

  // timing: delays count in microsecond ticks
  localparam int TICK_NS  = 1000;
  localparam int CLK_NS   = 4;
  localparam int TICK_CYC = TICK_NS / CLK_NS;

  // ahb transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;

  typedef enum logic [1:0] {
    DLS_M_ANGLE = 2'b00,
    DLS_M_PMIN  = 2'b01,
    DLS_M_NODIR = 2'b10,
    DLS_M_RSVD  = 2'b11
  } dls_method_e;

  // one set of measured grid quantities, same clock as the block
  typedef struct packed {
    logic [15:0]        freq;
    logic signed [23:0] pos_seq_active_power;
    logic signed [23:0] pos_seq_reactive_power;
    logic [15:0]        pos_seq_current;
    logic [15:0]        line_voltage;
  } dls_meas_s;

endpackage

// File: logic/dls_sync.sv
// two-flop synchroniser for a group of asynchronous binary inputs
`timescale 1ns/1ps
`default_nettype none
module dls_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta[g]   <= 1'b0;
        sync_o[g] <= 1'b0;
      end else begin
        meta[g]   <= async_i[g];
        sync_o[g] <= meta[g];
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/dls_delay_timer.sv
// trip delay timer counting microsecond ticks while its run input stays high
`timescale 1ns/1ps
`default_nettype none
module dls_delay_timer
  import dls_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        run_i,
  input  wire logic [31:0] delay_i,
  output logic             expired_o
);
  logic [15:0] pre;
  logic [31:0] ticks;
  wire         tick_done = (pre == 16'(TICK_CYCLES - 1));

  // dropping run clears everything, so a new alarm always waits the full delay
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre       <= 16'h0000;
      ticks     <= 32'h0000_0000;
      expired_o <= 1'b0;
    end else if (!run_i) begin
      pre       <= 16'h0000;
      ticks     <= 32'h0000_0000;
      expired_o <= 1'b0;
    end else begin
      pre       <= tick_done ? 16'h0000 : pre + 16'h0001;
      if (tick_done && ticks != 32'hffff_ffff) begin
        ticks <= ticks + 32'h0000_0001;
      end
      expired_o <= (ticks >= delay_i);
    end
  end
endmodule
`default_nettype wire

// File: logic/dls_underfreq_shedding.sv
// directional under-frequency load shedding decision with ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
module dls_underfreq_shedding
  import dls_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic            CLOCK_I,
  input  wire logic            RESETN_I,
  // ahb-lite slave
  input  wire logic            HSEL_I,
  input  wire logic [31:0]     HADDR_I,
  input  wire logic [1:0]      HTRANS_I,
  input  wire logic            HWRITE_I,
  input  wire logic [2:0]      HSIZE_I,
  input  wire logic [31:0]     HWDATA_I,
  input  wire logic            HREADY_I,
  output logic      [31:0]     HRDATA_O,
  output logic                 HREADYOUT_O,
  output logic                 HRESP_O,
  // measured quantities from the measurement logic
  input  wire dls_meas_s       MEAS_I,
  input  wire logic            MEAS_VALID_I,
  // assigned binary signals, asynchronous
  input  wire logic            DIR_EVAL_BLOCK_I,
  input  wire logic            EXTERNAL_DIRECTION_INPUT_I,
  input  wire logic            ADAPT_FREQ_I,
  input  wire logic            ADAPT_DELAY_I,
  // decisions
  output logic                 ALARM_O,
  output logic                 TRIP_O,
  output logic                 DIR_BLOCK_O,
  output logic                 IRQ_O
);

  // ---------------- binary input synchronisation
  logic [3:0] bin_sync;
  wire        dir_eval_block;
  wire        ext_dir;
  wire        adapt_freq;
  wire        adapt_delay;

  dls_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (RESETN_I),
    .async_i ({ADAPT_DELAY_I, ADAPT_FREQ_I,
               EXTERNAL_DIRECTION_INPUT_I, DIR_EVAL_BLOCK_I}),
    .sync_o  (bin_sync)
  );

  assign dir_eval_block = bin_sync[0];
  assign ext_dir        = bin_sync[1];
  assign adapt_freq     = bin_sync[2];
  assign adapt_delay    = bin_sync[3];

  // ---------------- configuration registers
  logic [CTRL_WIDTH-1:0] ctrl;
  logic [15:0]           freq_thr;
  logic [15:0]           freq_adp;
  logic [31:0]           delay;
  logic [31:0]           delay_adp;
  logic [15:0]           min_pos_seq_current;
  logic [15:0]           rel_volt;
  logic [15:0]           fblk_volt;
  logic [23:0]           pmin;
  logic [15:0]           angle_tan;
  logic [EV_WIDTH-1:0]   status;
  logic [EV_WIDTH-1:0]   mask;

  // ---------------- measurement hold
  dls_meas_s meas;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      meas <= '0;
    end else if (MEAS_VALID_I) begin
      meas <= MEAS_I;
    end
  end

  // ---------------- control fields
  wire         underfreq_shedding_en = ctrl[CTRL_ENABLE_BIT];
  wire         invert_power          = ctrl[CTRL_INVERT_BIT];
  wire         ext_dir_assigned      = ctrl[CTRL_EXTDIR_BIT];
  dls_method_e direction_method_select;
  assign direction_method_select =
    dls_method_e'(ctrl[CTRL_METHOD_LSB +: 2]);

  // ---------------- power sign and magnitude
  // positive p_eff means the feeder feeds the grid and so supports frequency
  wire signed [24:0] p_ext = {meas.pos_seq_active_power[23],
                              meas.pos_seq_active_power}; // R4
  wire signed [24:0] p_eff = invert_power ? -p_ext : p_ext; // R3
  wire               p_supports = (p_eff > 25'sd0);
  wire [23:0]        p_pos = p_supports ? p_eff[23:0] : 24'h000000;

  wire signed [23:0] q1 = meas.pos_seq_reactive_power;
  wire [23:0]        q_abs = q1[23] ? 24'(-q1) : q1;

  // angle area: |q| <= p * tan(angle), tan held as 8.8 fixed point
  wire [39:0] q_scaled = {8'h00, q_abs, 8'h00};
  wire [39:0] p_scaled = 40'(p_pos) * 40'(angle_tan);
  wire        in_angle_area = p_supports && (q_scaled <= p_scaled);

  wire signed [24:0] pmin_ext = {pmin[23], pmin};
  wire               above_pmin = (p_eff > pmin_ext);

  // ---------------- supervision conditions
  wire current_ok = (meas.pos_seq_current >= min_pos_seq_current); // R6
  wire volt_release = (meas.line_voltage >= rel_volt); // R7
  wire freq_valid = (meas.line_voltage >= fblk_volt); // R16

  wire [15:0] freq_limit = adapt_freq ? freq_adp : freq_thr; // R15
  wire [31:0] delay_sel  = adapt_delay ? delay_adp : delay; // R15

  wire underfreq = freq_valid && (meas.freq < freq_limit); // R16

  // ---------------- direction decision
  logic dir_block_raw;

  always_comb begin
    dir_block_raw = 1'b0;
    case (direction_method_select) // R8
      DLS_M_ANGLE: begin
        dir_block_raw = current_ok && in_angle_area; // R9 R6
      end
      DLS_M_PMIN: begin
        dir_block_raw = current_ok && above_pmin; // R10 R6
      end
      default: begin
        // nondirectional_or_external: shed on frequency alone unless the
        // external direction signal is assigned and reports infeed
        dir_block_raw = ext_dir_assigned && ext_dir; // R11 R12
      end
    endcase
  end

  // the evaluation block input forces classic shedding
  wire dir_block = dir_block_raw && !dir_eval_block; // R5 R1 R2

  wire next_alarm = underfreq_shedding_en && volt_release && underfreq &&
                    !dir_block; // R13 R1 R2

  // ---------------- trip delay
  logic alarm;
  logic timer_expired;

  dls_delay_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk_i     (CLOCK_I),
    .rst_n_i   (RESETN_I),
    .run_i     (alarm), // R14
    .delay_i   (delay_sel),
    .expired_o (timer_expired)
  );

  wire next_trip = alarm && timer_expired; // R17

  logic trip;
  logic dir_block_q;
  logic shed_blocked;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      alarm        <= 1'b0;
      trip         <= 1'b0;
      dir_block_q  <= 1'b0;
      shed_blocked <= 1'b0;
    end else begin
      alarm        <= next_alarm;
      trip         <= next_trip; // R17
      dir_block_q  <= dir_block;
      shed_blocked <= underfreq && dir_block && underfreq_shedding_en;
    end
  end

  // ---------------- event edges for the interrupt status
  logic alarm_d;
  logic trip_d;
  logic shed_blocked_d;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      alarm_d        <= 1'b0;
      trip_d         <= 1'b0;
      shed_blocked_d <= 1'b0;
    end else begin
      alarm_d        <= alarm;
      trip_d         <= trip;
      shed_blocked_d <= shed_blocked;
    end
  end

  wire [EV_WIDTH-1:0] ev_set;
  assign ev_set[EV_ALARM_BIT]  = alarm && !alarm_d;
  assign ev_set[EV_TRIP_BIT]   = trip && !trip_d;
  assign ev_set[EV_DIRBLK_BIT] = shed_blocked && !shed_blocked_d;

  // ---------------- ahb-lite address phase
  wire addr_take = HSEL_I && HTRANS_I[HTRANS_ACTIVE_BIT] && HREADY_I;
  wire [7:0] addr = HADDR_I[7:0];
  wire addr_hit_hi = (HADDR_I[31:8] == 24'h000000);

  logic       wr_pend;
  logic [7:0] wr_addr;

  // zero wait state: read data is sampled in the address phase, so a read
  // issued back to back behind a write to the same word returns the old value
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_take && HWRITE_I && addr_hit_hi;
      wr_addr <= addr;
    end
  end

  // ---------------- write decode (data phase)
  wire wr_ctrl      = wr_pend && (wr_addr == ADDR_CTRL);
  wire wr_freq_thr  = wr_pend && (wr_addr == ADDR_FREQ_THR);
  wire wr_freq_adp  = wr_pend && (wr_addr == ADDR_FREQ_ADP);
  wire wr_delay     = wr_pend && (wr_addr == ADDR_DELAY);
  wire wr_delay_adp = wr_pend && (wr_addr == ADDR_DELAY_ADP);
  wire wr_min_cur   = wr_pend && (wr_addr == ADDR_MIN_CUR);
  wire wr_rel_volt  = wr_pend && (wr_addr == ADDR_REL_VOLT);
  wire wr_fblk_volt = wr_pend && (wr_addr == ADDR_FBLK_VOLT);
  wire wr_pmin      = wr_pend && (wr_addr == ADDR_PMIN);
  wire wr_angle     = wr_pend && (wr_addr == ADDR_ANGLE_TAN);
  wire wr_status    = wr_pend && (wr_addr == ADDR_STATUS);
  wire wr_mask      = wr_pend && (wr_addr == ADDR_MASK);

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl                <= RST_CTRL;
      freq_thr            <= RST_FREQ_THR;
      freq_adp            <= RST_FREQ_ADP;
      delay               <= RST_DELAY;
      delay_adp           <= RST_DELAY_ADP;
      min_pos_seq_current <= RST_MIN_CUR;
      rel_volt            <= RST_REL_VOLT;
      fblk_volt           <= RST_FBLK_VOLT;
      pmin                <= RST_PMIN;
      angle_tan           <= RST_ANGLE_TAN;
      mask                <= RST_MASK;
    end else begin
      if (wr_ctrl)      ctrl                <= HWDATA_I[CTRL_WIDTH-1:0];
      if (wr_freq_thr)  freq_thr            <= HWDATA_I[15:0];
      if (wr_freq_adp)  freq_adp            <= HWDATA_I[15:0];
      if (wr_delay)     delay               <= HWDATA_I;
      if (wr_delay_adp) delay_adp           <= HWDATA_I;
      if (wr_min_cur)   min_pos_seq_current <= HWDATA_I[15:0];
      if (wr_rel_volt)  rel_volt            <= HWDATA_I[15:0];
      if (wr_fblk_volt) fblk_volt           <= HWDATA_I[15:0];
      if (wr_pmin)      pmin                <= HWDATA_I[23:0];
      if (wr_angle)     angle_tan           <= HWDATA_I[15:0];
      if (wr_mask)      mask                <= HWDATA_I[EV_WIDTH-1:0];
    end
  end

  // write-one-to-clear; a new event in the clearing cycle survives
  wire [EV_WIDTH-1:0] ev_clr = wr_status ? HWDATA_I[EV_WIDTH-1:0] : '0;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      status <= '0;
    end else begin
      status <= (status & ~ev_clr) | ev_set;
    end
  end

  // ---------------- read decode (address phase)
  wire [STATE_WIDTH-1:0] live_state = {freq_valid, current_ok, volt_release,
                                       underfreq, dir_block_q, trip, alarm};
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (!addr_hit_hi) begin
      rd_mux = 32'h0000_0000;
    end else if (addr == ADDR_CTRL) begin
      rd_mux = 32'(ctrl);
    end else if (addr == ADDR_FREQ_THR) begin
      rd_mux = 32'(freq_thr);
    end else if (addr == ADDR_FREQ_ADP) begin
      rd_mux = 32'(freq_adp);
    end else if (addr == ADDR_DELAY) begin
      rd_mux = delay;
    end else if (addr == ADDR_DELAY_ADP) begin
      rd_mux = delay_adp;
    end else if (addr == ADDR_MIN_CUR) begin
      rd_mux = 32'(min_pos_seq_current);
    end else if (addr == ADDR_REL_VOLT) begin
      rd_mux = 32'(rel_volt);
    end else if (addr == ADDR_FBLK_VOLT) begin
      rd_mux = 32'(fblk_volt);
    end else if (addr == ADDR_PMIN) begin
      rd_mux = 32'(pmin);
    end else if (addr == ADDR_ANGLE_TAN) begin
      rd_mux = 32'(angle_tan);
    end else if (addr == ADDR_STATUS) begin
      rd_mux = 32'(status);
    end else if (addr == ADDR_MASK) begin
      rd_mux = 32'(mask);
    end else if (addr == ADDR_STATE) begin
      rd_mux = 32'(live_state);
    end
  end

  wire rd_take = addr_take && !HWRITE_I;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      HRDATA_O    <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HRDATA_O    <= rd_take ? rd_mux : 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // ---------------- output registers
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ALARM_O     <= 1'b0;
      TRIP_O      <= 1'b0;
      DIR_BLOCK_O <= 1'b0;
      IRQ_O       <= 1'b0;
    end else begin
      ALARM_O     <= alarm;
      TRIP_O      <= trip; // R17
      DIR_BLOCK_O <= dir_block_q;
      IRQ_O       <= |(status & mask);
    end
  end

endmodule
`default_nettype wire

// File: tb/dls_underfreq_shedding_chk.sv
// port checker for the under-frequency shedding block
`timescale 1ns/1ps
`default_nettype none
module dls_underfreq_shedding_chk
  import dls_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic        CLOCK_I,
  input wire logic        RESETN_I,
  input wire logic        HSEL_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  input wire dls_meas_s   MEAS_I,
  input wire logic        MEAS_VALID_I,
  input wire logic        ALARM_O,
  input wire logic        TRIP_O,
  input wire logic        DIR_BLOCK_O,
  input wire logic        IRQ_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  wire rd_taken = HSEL_I && HTRANS_I[HTRANS_ACTIVE_BIT] && HREADY_I && !HWRITE_I;

  bus_okay_a: assert property (HREADYOUT_O && !HRESP_O)
    else $error("bus slave stalled or answered with an error");
  rdata_idle_a: assert property (HRDATA_O != 32'h0 |-> $past(rd_taken))
    else $error("read data driven outside a read data phase");
  // a frequency at full scale is never below any threshold
  high_freq_a: assert property (MEAS_VALID_I && MEAS_I.freq == 16'hffff |-> ##3 !ALARM_O)
    else $error("alarm raised without under-frequency");
  wire volt_low = MEAS_VALID_I && (MEAS_I.line_voltage < RST_FBLK_VOLT); // never rewritten
  low_volt_a: assert property (volt_low |-> ##3 !ALARM_O)
    else $error("alarm raised while voltage is too low");
  dir_excl_a: assert property (DIR_BLOCK_O [*3] |-> !ALARM_O)
    else $error("alarm raised on a supporting feeder");
  trip_alarm_a: assert property (TRIP_O |-> ALARM_O || $past(ALARM_O))
    else $error("trip without a standing alarm");
  trip_early_a: assert property ($rose(ALARM_O) |-> !TRIP_O [*2])
    else $error("trip at the moment the alarm rose");
  trip_rise_a: assert property ($rose(TRIP_O) |-> $past(ALARM_O, 2))
    else $error("trip rose without alarm held before");

  alarm_c: cover property ($rose(ALARM_O));
  trip_c: cover property ($rose(TRIP_O));
  dir_c: cover property ($rose(DIR_BLOCK_O));
  irq_c: cover property ($rose(IRQ_O));
endmodule
`default_nettype wire

// File: tb/dls_grid_model.sv
// grid measurement and assigned binary signal source facing the block
`timescale 1ns/1ps
`default_nettype none
module dls_grid_model
  import dls_pkg::*;
(
  input  wire logic       clk_i,
  output var  dls_meas_s  meas_o,
  output var  logic       meas_valid_o,
  output var  logic [3:0] bin_o
);
  initial begin
    meas_o = '0;
    meas_valid_o = 1'b0;
    bin_o = 4'h0;
  end

  // frequency, line voltage and positive-sequence quantities are handed over; valid stays up as a level
  task automatic apply(input logic [15:0] f, input logic signed [23:0] p,
                       input logic signed [23:0] q, input logic [15:0] cur,
                       input logic [15:0] v);
    @(posedge clk_i);
    meas_o <= '{f, p, q, cur, v};
    meas_valid_o <= 1'b1;
  endtask

  // bit0 direction block, bit1 external direction, bit2 adapt freq, bit3 adapt delay
  task automatic set_bin(input logic [3:0] b);
    @(posedge clk_i);
    bin_o <= b;
  endtask
endmodule
`default_nettype wire

// File: tb/dls_underfreq_shedding_bench.sv
// self-checking bench for the under-frequency shedding block
`timescale 1ns/1ps
`default_nettype none
module dls_underfreq_shedding_bench;
  import dls_pkg::*;
  localparam int TCYC = 4;
  localparam logic [15:0] F_LOW = 16'hb000;
  localparam logic [15:0] F_MID = 16'hbd00;
  localparam logic [15:0] V_OK  = 16'h0200;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  wire  [31:0] hrdata;
  wire         hready, hresp, alarm, trip, dirblk, irq, meas_valid;
  wire  [3:0]  bin;
  wire dls_meas_s meas;
  int          error_cnt = 0;
  int          comparisons = 0;

  always #2 clk = ~clk;

  dls_grid_model gm (.clk_i(clk), .meas_o(meas), .meas_valid_o(meas_valid), .bin_o(bin));
  dls_underfreq_shedding #(.TICK_CYCLES(TCYC)) DUT (
    .CLOCK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .MEAS_I(meas),
    .MEAS_VALID_I(meas_valid), .DIR_EVAL_BLOCK_I(bin[0]), .EXTERNAL_DIRECTION_INPUT_I(bin[1]),
    .ADAPT_FREQ_I(bin[2]), .ADAPT_DELAY_I(bin[3]), .ALARM_O(alarm), .TRIP_O(trip),
    .DIR_BLOCK_O(dirblk), .IRQ_O(irq));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // waits on hready with a bound, though the slave never inserts wait states
  task automatic wait_ready();
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      $display("[FAIL] hready expected 1 seen %b", hready);
      conclude();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check($sformatf("register %h", a), exp, x);
  endtask

  // two sync flops, two pipeline stages and the model's own edge
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  task automatic t_reset();
    logic [7:0]  adr[13] = '{ADDR_CTRL, ADDR_FREQ_THR, ADDR_FREQ_ADP, ADDR_DELAY,
                             ADDR_DELAY_ADP, ADDR_MIN_CUR, ADDR_REL_VOLT, ADDR_FBLK_VOLT,
                             ADDR_PMIN, ADDR_ANGLE_TAN, ADDR_MASK, ADDR_STATUS, 8'h40};
    logic [31:0] rv[13] = '{32'h0, 32'hbf68, 32'hbb80, 32'h64, 32'hc8, 32'h10, 32'h100,
                            32'h80, 32'h0, 32'h100, 32'h0, 32'h0, 32'h0};
    wr(8'h40, 32'hffff_ffff);
    for (int i = 0; i < 13; i++) begin
      rdc(adr[i], rv[i]);
    end
    $display("test reset done");
  endtask

  // one direction case: control word, power, reactive, current, binaries, outcome
  task automatic row(input logic [31:0] c, input logic signed [23:0] p,
                     input logic signed [23:0] q, input logic [15:0] cur,
                     input logic [3:0] b, input logic ea, input logic ed);
    wr(ADDR_CTRL, c);
    gm.set_bin(b);
    gm.apply(F_LOW, p, q, cur, V_OK);
    settle();
    check($sformatf("alarm ctrl %h", c), {31'h0, ea}, {31'h0, alarm});
    check($sformatf("dir block ctrl %h", c), {31'h0, ed}, {31'h0, dirblk});
  endtask

  task automatic t_direction();
    wr(ADDR_PMIN, 32'h100);
    row(32'h01, 24'sh1000, 24'sh0, 16'h40, 4'h0, 1'b0, 1'b1);
    row(32'h01, 24'sh1000, 24'sh2000, 16'h40, 4'h0, 1'b1, 1'b0);
    row(32'h01, -24'sh1000, 24'sh0, 16'h40, 4'h0, 1'b1, 1'b0);
    row(32'h09, -24'sh1000, 24'sh0, 16'h40, 4'h0, 1'b0, 1'b1);
    row(32'h01, 24'sh1000, 24'sh0, 16'h08, 4'h0, 1'b1, 1'b0);
    row(32'h01, 24'sh1000, 24'sh0, 16'h40, 4'h1, 1'b1, 1'b0);
    row(32'h03, 24'sh0200, 24'sh0, 16'h40, 4'h0, 1'b0, 1'b1);
    row(32'h03, 24'sh0080, 24'sh0, 16'h40, 4'h0, 1'b1, 1'b0);
    row(32'h15, 24'sh1000, 24'sh0, 16'h40, 4'h2, 1'b0, 1'b1);
    row(32'h15, 24'sh1000, 24'sh0, 16'h40, 4'h0, 1'b1, 1'b0);
    row(32'h05, 24'sh1000, 24'sh0, 16'h40, 4'h2, 1'b1, 1'b0);
    row(32'h07, 24'sh1000, 24'sh0, 16'h40, 4'h0, 1'b1, 1'b0);
    $display("test direction done");
  endtask

  // clears any alarm, then times the trip from the alarm edge
  task automatic trip_time(input int ticks);
    int n = 0;
    gm.apply(16'hffff, 24'sh0, 24'sh0, 16'h40, V_OK);
    settle();
    check("trip after alarm drop", 32'h0, {31'h0, trip});
    gm.apply(F_LOW, 24'sh0, 24'sh0, 16'h40, V_OK);
    while (alarm !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check("alarm rise", 32'h1, {31'h0, alarm});
    if (alarm !== 1'b1) conclude();
    n = 0;
    while (trip !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check("trip delay window", 32'h1, {31'h0, n >= ticks * TCYC && n <= ticks * TCYC + 6});
    if (n >= 200) conclude();
  endtask

  task automatic t_timing();
    wr(ADDR_CTRL, 32'h05);
    wr(ADDR_DELAY, 32'h3);
    wr(ADDR_DELAY_ADP, 32'h8);
    trip_time(3);
    gm.set_bin(4'h8);
    trip_time(8);
    gm.apply(F_MID, 24'sh0, 24'sh0, 16'h40, V_OK);
    settle();
    check("alarm mid frequency", 32'h1, {31'h0, alarm});
    gm.set_bin(4'h4);
    settle();
    check("alarm adaptive frequency", 32'h0, {31'h0, alarm});
    wr(ADDR_DELAY, 32'h64);
    $display("test timing done");
  endtask

  task automatic t_voltage();
    gm.set_bin(4'h0);
    gm.apply(F_LOW, 24'sh0, 24'sh0, 16'h40, 16'h00c0);
    settle();
    check("alarm below release voltage", 32'h0, {31'h0, alarm});
    wr(ADDR_REL_VOLT, 32'h40);
    gm.apply(F_LOW, 24'sh0, 24'sh0, 16'h40, 16'h0060);
    settle();
    check("alarm below blocking voltage", 32'h0, {31'h0, alarm});
    gm.apply(F_LOW, 24'sh0, 24'sh0, 16'h40, 16'h0090);
    settle();
    check("alarm above both voltages", 32'h1, {31'h0, alarm});
    wr(ADDR_REL_VOLT, 32'h100);
    $display("test voltage done");
  endtask

  task automatic t_irq();
    gm.apply(16'hffff, 24'sh0, 24'sh0, 16'h40, V_OK);
    settle();
    wr(ADDR_STATUS, 32'h7);
    wr(ADDR_MASK, 32'h1);
    gm.apply(F_LOW, 24'sh0, 24'sh0, 16'h40, V_OK);
    settle();
    check("irq on alarm", 32'h1, {31'h0, irq});
    rdc(ADDR_STATUS, 32'h1);
    gm.apply(16'hffff, 24'sh0, 24'sh0, 16'h40, V_OK);
    settle();
    check("irq sticky", 32'h1, {31'h0, irq});
    wr(ADDR_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    wr(ADDR_MASK, 32'h0);
    gm.apply(F_LOW, 24'sh0, 24'sh0, 16'h40, V_OK);
    settle();
    check("irq masked", 32'h0, {31'h0, irq});
    rdc(ADDR_STATUS, 32'h1);
    $display("test irq done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_direction();
    t_timing();
    t_voltage();
    t_irq();
    conclude();
  end
endmodule

bind dls_underfreq_shedding dls_underfreq_shedding_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I),
  .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .MEAS_I(MEAS_I), .MEAS_VALID_I(MEAS_VALID_I), .ALARM_O(ALARM_O),
  .TRIP_O(TRIP_O), .DIR_BLOCK_O(DIR_BLOCK_O), .IRQ_O(IRQ_O));
`default_nettype wire
